//--- include/sfoc_pkg.sv
// Constants, types and decode functions of the serial flash operation control block
//
// Notes on behaviour
// - Buffer read, buffer write and status read work while an array operation runs.
// - One buffer may be loaded while the other is programmed into the array.
// - With protect input low, the lowest 256 pages cannot be reprogrammed.
// - Protect input is pulled up, so an open pin means no protection.
// - Reset input low aborts the running operation and forces the idle state.
// - Device stays reset while reset input is low and resumes when high.
// - Power-on reset is internal; the reset input needs no power-up sequencing.
// - Reset input is pulled up, so it may be left unconnected.
// - Ready/busy is open drain, pulled low only during self-timed operations.
// - Busy shows during program, erase, compare and page-to-buffer transfer.
// - While busy, array and involved buffer are blocked; other buffer stays usable.
// - After power-up or reset: clock mode 3 and serial output high impedance.
// - A chip-select falling edge must precede any command; otherwise bits ignored.
// - At each chip-select fall, idle clock low selects mode 0, high mode 3.
// - Serial input bits are captured on the rising clock edge in both modes.
// - Page-to-buffer transfer or compare finishes within 200 us.
// - Erase+program 20 ms, program 15 ms, page erase 10 ms, block erase 15 ms.
// - Status bit 7 is 1 when ready and 0 while busy.
// - Status bit 6 holds the latest compare result: 0 match, 1 mismatch.
package sfoc_pkg;
  localparam int unsigned SYS_HZ = 25_000_000;
  localparam int unsigned T_XFR_US = 200;
  localparam int unsigned T_EP_MS = 20;
  localparam int unsigned T_P_MS = 15;
  localparam int unsigned T_PE_MS = 10;
  localparam int unsigned T_BE_MS = 15;
  localparam int unsigned CYC_XFR = T_XFR_US * (SYS_HZ / 1_000_000);
  localparam int unsigned CYC_EP = T_EP_MS * (SYS_HZ / 1_000);
  localparam int unsigned CYC_P = T_P_MS * (SYS_HZ / 1_000);
  localparam int unsigned CYC_PE = T_PE_MS * (SYS_HZ / 1_000);
  localparam int unsigned CYC_BE = T_BE_MS * (SYS_HZ / 1_000);
  localparam int TMR_W = 20;
  localparam int CMD_W = 32;
  localparam int OPC_HI = 31;
  localparam int OPC_LO = 24;
  localparam int PAGE_HI = 22;
  localparam int PAGE_LO = 10;
  localparam int BADR_HI = 9;
  localparam int BADR_LO = 0;
  localparam logic [5:0] CMD_LAST = 6'h1f;
  localparam logic [5:0] CMD_DONE = 6'h20;
  localparam logic [5:0] OPC_LAST = 6'h07;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [12:0] PROT_PAGES = 13'h0100;
  localparam logic [9:0] BUF_LAST = 10'h020f;
  // Density code value is arbitrary
  localparam logic [2:0] DENSITY_ID = 3'h5;
  localparam logic [2:0] STAT_RSVD = 3'h0;
  localparam logic [7:0] OPC_STATUS = 8'h57;

  typedef enum logic [3:0] {
    K_NONE, K_XFER, K_CMP, K_PGM_ER, K_PGM, K_PERASE, K_BERASE,
    K_MMPROG, K_REWRITE, K_BWRITE, K_BREAD, K_MMREAD, K_STATUS
  } sfoc_kind_t;

  typedef enum logic {ST_IDLE, ST_BUSY} sfoc_st_t;

  function automatic sfoc_kind_t sfoc_kind(input logic [7:0] opc);
    case (opc)
      8'h53, 8'h55: sfoc_kind = K_XFER;
      8'h60, 8'h61: sfoc_kind = K_CMP;
      8'h83, 8'h86: sfoc_kind = K_PGM_ER;
      8'h88, 8'h89: sfoc_kind = K_PGM;
      8'h81: sfoc_kind = K_PERASE;
      8'h50: sfoc_kind = K_BERASE;
      8'h82, 8'h85: sfoc_kind = K_MMPROG;
      8'h58, 8'h59: sfoc_kind = K_REWRITE;
      8'h84, 8'h87: sfoc_kind = K_BWRITE;
      8'h54, 8'h56: sfoc_kind = K_BREAD;
      8'h52: sfoc_kind = K_MMREAD;
      OPC_STATUS: sfoc_kind = K_STATUS;
      default: sfoc_kind = K_NONE;
    endcase
  endfunction

  function automatic logic sfoc_buf2(input logic [7:0] opc);
    case (opc)
      8'h55, 8'h61, 8'h86, 8'h89, 8'h85, 8'h59, 8'h87, 8'h56: sfoc_buf2 = 1'b1;
      default: sfoc_buf2 = 1'b0;
    endcase
  endfunction
endpackage

//--- design/sfoc_sync.sv
// Two-flop synchroniser for pin levels entering the system clock domain
`timescale 1ns/1ns
`default_nettype none
module sfoc_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } sfoc_sync_t;

  sfoc_sync_t r_r;
  sfoc_sync_t r_nxt;

  always_comb begin
    r_nxt = r_r;
    r_nxt.meta = d_i;
    r_nxt.q = r_r.meta;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      r_r <= '0;
    end else if (clk_en_i) begin
      r_r <= r_nxt;
    end
  end

  assign q_o = r_r.q;
endmodule
`default_nettype wire

//--- design/sfoc_link.sv
// Serial link shifter on the host clock: command capture, data bytes, status output
`timescale 1ns/1ns
`default_nettype none
module sfoc_link
  import sfoc_pkg::*;
(
  input wire logic spi_sck_i,
  input wire logic spi_cs_n_i,
  input wire logic rst_i,
  input wire logic spi_si_i,
  input wire logic busy_i,
  input wire logic cmp_i,
  output logic [CMD_W-1:0] cmd_word_o,
  output logic cmd_full_o,
  output logic [7:0] byte_o,
  output logic byte_tgl_o,
  output logic so_o,
  output logic so_oe_o
);
  // Frame state, cleared whenever chip select is high
  typedef struct packed {
    logic [5:0] cnt;
    logic [CMD_W-1:0] sh;
    logic [2:0] bcnt;
    logic stat;
  } sfoc_frm_t;

  // Held state, survives the end of a frame for the system side to read
  typedef struct packed {
    logic [CMD_W-1:0] word;
    logic full;
    logic [7:0] dbyte;
    logic tgl;
    logic busy_m;
    logic busy_s;
    logic cmp_m;
    logic cmp_s;
  } sfoc_hold_t;

  typedef struct packed {
    logic so;
    logic oe;
    logic [2:0] idx;
  } sfoc_out_t;

  sfoc_frm_t f_r;
  sfoc_frm_t f_nxt;
  sfoc_hold_t h_r;
  sfoc_hold_t h_nxt;
  sfoc_out_t o_r;
  sfoc_out_t o_nxt;
  logic [CMD_W-1:0] sh_in;
  logic [7:0] stat_byte;
  logic frm_rst;

  assign frm_rst = rst_i | spi_cs_n_i;
  assign sh_in = {f_r.sh[CMD_W-2:0], spi_si_i};
  assign stat_byte = {~h_r.busy_s, h_r.cmp_s, DENSITY_ID, STAT_RSVD};

  always_comb begin
    f_nxt = f_r;
    h_nxt = h_r;
    h_nxt.busy_m = busy_i;
    h_nxt.busy_s = h_r.busy_m;
    h_nxt.cmp_m = cmp_i;
    h_nxt.cmp_s = h_r.cmp_m;
    f_nxt.sh = sh_in;
    if (f_r.cnt == '0) begin
      h_nxt.full = 1'b0;
    end
    if (f_r.cnt != CMD_DONE) begin
      f_nxt.cnt = 6'(f_r.cnt + 6'h01);
    end
    if (f_r.cnt == OPC_LAST && sh_in[7:0] == OPC_STATUS) begin
      f_nxt.stat = 1'b1;
    end
    if (f_r.cnt == CMD_LAST) begin
      h_nxt.word = sh_in;
      h_nxt.full = 1'b1;
    end
    if (f_r.cnt == CMD_DONE) begin
      f_nxt.bcnt = 3'(f_r.bcnt + 3'h1);
      if (f_r.bcnt == BIT_LAST) begin
        h_nxt.dbyte = sh_in[7:0];
        h_nxt.tgl = ~h_r.tgl;
      end
    end
  end

  always_comb begin
    o_nxt = o_r;
    o_nxt.oe = f_r.stat;
    if (f_r.stat) begin
      o_nxt.so = stat_byte[~o_r.idx];
      o_nxt.idx = 3'(o_r.idx + 3'h1);
    end
  end

  always_ff @(posedge spi_sck_i or posedge frm_rst) begin
    if (frm_rst) begin
      f_r <= '0;
    end else begin
      f_r <= f_nxt;
    end
  end

  always_ff @(posedge spi_sck_i or posedge rst_i) begin
    if (rst_i) begin
      h_r <= '0;
    end else begin
      h_r <= h_nxt;
    end
  end

  // Output changes on the falling edge, ahead of the host's rising sample
  always_ff @(negedge spi_sck_i or posedge frm_rst) begin
    if (frm_rst) begin
      o_r <= '0;
    end else begin
      o_r <= o_nxt;
    end
  end

  assign cmd_word_o = h_r.word;
  assign cmd_full_o = h_r.full;
  assign byte_o = h_r.dbyte;
  assign byte_tgl_o = h_r.tgl;
  assign so_o = o_r.so;
  assign so_oe_o = o_r.oe;
endmodule
`default_nettype wire

//--- design/sfoc_top.sv
// Operation control of a two-buffer serial flash: busy timing, protection, modes
`timescale 1ns/1ns
`default_nettype none
module sfoc_top
  import sfoc_pkg::*;
#(
  parameter int unsigned XFR_CYC = CYC_XFR,
  parameter int unsigned EP_CYC = CYC_EP,
  parameter int unsigned P_CYC = CYC_P,
  parameter int unsigned PE_CYC = CYC_PE,
  parameter int unsigned BE_CYC = CYC_BE
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic spi_sck_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_si_i,
  input wire logic wp_n_i,
  input wire logic reset_n_i,
  input wire logic array_mismatch_i,
  output logic spi_so_o,
  output logic spi_so_oe_o,
  output logic rdy_busy_o,
  output logic rdy_busy_oe_o,
  output logic spi_mode3_o,
  output logic array_start_o,
  output sfoc_kind_t array_kind_o,
  output logic [12:0] array_page_o,
  output logic array_buf_o,
  output logic array_abort_o,
  output logic cmd_reject_o,
  output logic buf_wr_o,
  output logic buf_wr_sel_o,
  output logic [9:0] buf_wr_addr_o,
  output logic [7:0] buf_wr_data_o
);
  typedef struct packed {
    sfoc_st_t st;
    sfoc_kind_t kind;
    logic [12:0] page;
    logic bsel;
    logic lock;
    logic [TMR_W-1:0] tmr;
    logic cmp;
    logic mode3;
    logic frame_ok;
    logic cs_d;
    logic tgl_d;
    logic [9:0] baddr;
    logic bfirst;
    logic start;
    logic abort;
    logic reject;
    logic bwr;
    logic bwr_sel;
    logic [7:0] bwr_data;
  } sfoc_top_t;

  sfoc_top_t r_r;
  sfoc_top_t r_nxt;

  logic [CMD_W-1:0] cmd_word;
  logic cmd_full;
  logic [7:0] link_byte;
  logic link_tgl;
  logic link_so;
  logic link_oe;
  logic [4:0] pin_s;
  logic cs_s;
  logic sck_s;
  logic wp_s;
  logic rstp_s;
  logic tgl_s;
  logic cs_fall;
  logic frame_end;
  logic byte_ev;
  logic busy;
  logic arr_op;
  logic wr_op;
  logic locks;
  logic prot;
  logic buf_now;
  logic buf_blocked;
  sfoc_kind_t kind_now;
  logic [12:0] page_now;

  // Pins and the link's byte toggle enter through two flops
  sfoc_sync #(.W(5)) sfoc_sync_inst (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .clk_en_i(clk_en_i),
    .d_i({spi_cs_n_i, spi_sck_i, wp_n_i, reset_n_i, link_tgl}),
    .q_o(pin_s)
  );

  sfoc_link sfoc_link_inst (
    .spi_sck_i(spi_sck_i),
    .spi_cs_n_i(spi_cs_n_i),
    .rst_i(rst_i),
    .spi_si_i(spi_si_i),
    .busy_i(busy),
    .cmp_i(r_r.cmp),
    .cmd_word_o(cmd_word),
    .cmd_full_o(cmd_full),
    .byte_o(link_byte),
    .byte_tgl_o(link_tgl),
    .so_o(link_so),
    .so_oe_o(link_oe)
  );

  // Pull-ups on protect and reset pins are pad cells; an open pin reads high here
  assign {cs_s, sck_s, wp_s, rstp_s, tgl_s} = pin_s;
  assign cs_fall = r_r.cs_d & ~cs_s;
  assign frame_end = ~r_r.cs_d & cs_s & r_r.frame_ok & cmd_full;
  assign byte_ev = (tgl_s != r_r.tgl_d) & r_r.frame_ok & cmd_full;
  assign busy = (r_r.st == ST_BUSY);
  assign kind_now = sfoc_kind(cmd_word[OPC_HI:OPC_LO]);
  assign buf_now = sfoc_buf2(cmd_word[OPC_HI:OPC_LO]);
  assign page_now = cmd_word[PAGE_HI:PAGE_LO];
  assign arr_op = kind_now inside {K_XFER, K_CMP, K_PGM_ER, K_PGM, K_PERASE, K_BERASE,
                                   K_MMPROG, K_REWRITE};
  assign wr_op = kind_now inside {K_PGM_ER, K_PGM, K_PERASE, K_BERASE, K_MMPROG, K_REWRITE};
  assign locks = !(kind_now inside {K_PERASE, K_BERASE});
  assign prot = wr_op & ~wp_s & (page_now < PROT_PAGES);
  assign buf_blocked = busy & r_r.lock & (r_r.bsel == buf_now);

  function automatic logic [TMR_W-1:0] dur(input sfoc_kind_t k);
    case (k)
      K_XFER, K_CMP: dur = TMR_W'(XFR_CYC - 1);
      K_PGM_ER, K_MMPROG, K_REWRITE: dur = TMR_W'(EP_CYC - 1);
      K_PGM: dur = TMR_W'(P_CYC - 1);
      K_PERASE: dur = TMR_W'(PE_CYC - 1);
      K_BERASE: dur = TMR_W'(BE_CYC - 1);
      default: dur = '0;
    endcase
  endfunction

  always_comb begin
    r_nxt = r_r;
    r_nxt.start = 1'b0;
    r_nxt.abort = 1'b0;
    r_nxt.reject = 1'b0;
    r_nxt.bwr = 1'b0;
    r_nxt.cs_d = cs_s;
    r_nxt.tgl_d = tgl_s;
    if (cs_fall) begin
      r_nxt.mode3 = sck_s;
      r_nxt.frame_ok = 1'b1;
      r_nxt.bfirst = 1'b1;
    end
    if (cs_s) begin
      r_nxt.frame_ok = 1'b0;
    end
    // Buffer loads run beside an array operation unless they hit its buffer
    if (byte_ev && (kind_now inside {K_BWRITE, K_MMPROG})) begin
      r_nxt.bfirst = 1'b0;
      if (r_r.bfirst) begin
        r_nxt.baddr = cmd_word[BADR_HI:BADR_LO];
      end else if (r_r.baddr == BUF_LAST) begin
        r_nxt.baddr = '0;
      end else begin
        r_nxt.baddr = 10'(r_r.baddr + 10'h001);
      end
      if (buf_blocked) begin
        r_nxt.reject = 1'b1;
      end else begin
        r_nxt.bwr = 1'b1;
        r_nxt.bwr_sel = buf_now;
        r_nxt.bwr_data = link_byte;
      end
    end
    case (r_r.st)
      ST_IDLE: begin
        if (frame_end && arr_op) begin
          if (prot) begin
            r_nxt.reject = 1'b1;
          end else begin
            r_nxt.st = ST_BUSY;
            r_nxt.start = 1'b1;
            r_nxt.kind = kind_now;
            r_nxt.page = page_now;
            r_nxt.bsel = buf_now;
            r_nxt.lock = locks;
            r_nxt.tmr = dur(kind_now);
          end
        end
      end
      ST_BUSY: begin
        if (frame_end && arr_op) begin
          r_nxt.reject = 1'b1;
        end
        if (r_r.tmr == '0) begin
          r_nxt.st = ST_IDLE;
          if (r_r.kind == K_CMP) begin
            r_nxt.cmp = array_mismatch_i;
          end
        end else begin
          r_nxt.tmr = TMR_W'(r_r.tmr - 1'b1);
        end
      end
      default: begin
        r_nxt.st = ST_IDLE;
      end
    endcase
    // Reset pin held low keeps everything idle and drops the frame
    if (!rstp_s) begin
      r_nxt.abort = busy;
      r_nxt.st = ST_IDLE;
      r_nxt.start = 1'b0;
      r_nxt.reject = 1'b0;
      r_nxt.bwr = 1'b0;
      r_nxt.tmr = '0;
      r_nxt.mode3 = 1'b1;
      r_nxt.frame_ok = 1'b0;
    end
  end

  // Internal power-on reset arrives on rst_i
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      r_r <= '0;
      r_r.mode3 <= 1'b1;
    end else if (clk_en_i) begin
      r_r <= r_nxt;
    end
  end

  assign spi_so_o = link_so;
  assign spi_so_oe_o = link_oe & r_r.frame_ok;
  assign rdy_busy_o = 1'b0;
  assign rdy_busy_oe_o = busy;
  assign spi_mode3_o = r_r.mode3;
  assign array_start_o = r_r.start;
  assign array_kind_o = r_r.kind;
  assign array_page_o = r_r.page;
  assign array_buf_o = r_r.bsel;
  assign array_abort_o = r_r.abort;
  assign cmd_reject_o = r_r.reject;
  assign buf_wr_o = r_r.bwr;
  assign buf_wr_sel_o = r_r.bwr_sel;
  assign buf_wr_addr_o = r_r.baddr;
  assign buf_wr_data_o = r_r.bwr_data;

  // Helper: cycles spent busy in the current operation
  logic [TMR_W-1:0] busy_cnt_r;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_cnt_r <= '0;
    end else if (clk_en_i) begin
      busy_cnt_r <= busy ? TMR_W'(busy_cnt_r + 1'b1) : '0;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i || !clk_en_i);

  start_busy_a: assert property (array_start_o |-> rdy_busy_oe_o)
    else $error("operation started without busy");
  busy_hold_a: assert property ($rose(rdy_busy_oe_o) && rstp_s |-> ##1 rdy_busy_oe_o)
    else $error("busy dropped too early");
  busy_len_a: assert property (busy |-> busy_cnt_r <= dur(r_r.kind))
    else $error("busy exceeds operation time");
  prot_refuse_a: assert property (frame_end && !busy && prot && rstp_s |=>
                                  cmd_reject_o && !array_start_o)
    else $error("protected page not refused");
  second_op_a: assert property (frame_end && busy && arr_op && rstp_s |=>
                               cmd_reject_o && !array_start_o)
    else $error("second array operation not refused");
  lock_buf_a: assert property (buf_wr_o && $past(busy) && $past(r_r.lock) |->
                              buf_wr_sel_o != $past(r_r.bsel))
    else $error("write reached the locked buffer");
  free_buf_a: assert property (byte_ev && (kind_now == K_BWRITE) && !buf_blocked && rstp_s
                              |=> buf_wr_o)
    else $error("buffer write dropped during busy");
  pin_abort_a: assert property (!rstp_s |=> !rdy_busy_oe_o && !array_start_o
                               && spi_mode3_o)
    else $error("reset pin did not force idle");
  mode_pick_a: assert property (cs_fall && rstp_s |=> spi_mode3_o == $past(sck_s))
    else $error("clock mode not taken at select fall");
  no_arm_a: assert property (!r_r.frame_ok |-> !spi_so_oe_o)
    else $error("output driven outside an armed frame");
  cmp_keep_a: assert property (busy && r_r.kind == K_CMP && r_r.tmr == '0 && rstp_s
                              |=> r_r.cmp == $past(array_mismatch_i))
    else $error("compare result not stored");

  cov_start_c: cover property (array_start_o ##1 rdy_busy_oe_o ##[1:1000] !rdy_busy_oe_o);
  cov_pingpong_c: cover property (busy && buf_wr_o);
  cov_reject_c: cover property (busy && cmd_reject_o);
  cov_mode0_c: cover property (cs_fall && !sck_s);
endmodule
`default_nettype wire

//--- verification/sfoc_host_model.sv
// Host controller model: drives chip select, serial clock and serial input
`timescale 1ns/1ns
`default_nettype none
module sfoc_host_model (
  input wire logic so_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic si_o
);
  initial begin
    sck_o = 1'b1;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end

  // One bit: data set after the falling edge and held across the rising edge
  task automatic bit_x(input logic v, inout logic [7:0] rx);
    sck_o = 1'b0;
    si_o = v;
    #80;
    sck_o = 1'b1;
    rx = {rx[6:0], so_i};
    #80;
  endtask

  // Whole frame in mode 0 or 3; rx keeps the last eight bits seen on the output
  task automatic frame(input logic m3, input logic [31:0] cmd, input int nb,
                       input logic [7:0] dat, output logic [7:0] rx);
    logic [7:0] d;
    int i;
    int j;
    rx = 8'h00;
    // Start off the system clock edge; the link clock has no fixed phase to it
    #7;
    sck_o = m3;
    #40;
    cs_n_o = 1'b0;
    #120;
    for (i = 0; i < 32; i++) bit_x(cmd[31-i], rx);
    for (j = 0; j < nb; j++) begin
      d = dat + 8'(j);
      for (i = 0; i < 8; i++) bit_x(d[7-i], rx);
    end
    sck_o = m3;
    #120;
    cs_n_o = 1'b1;
    // Released line shows the inverse of its last value
    si_o = ~si_o;
    #300;
  endtask
endmodule
`default_nettype wire

//--- verification/serial_flash_op_control_tb.sv
// Self-checking testbench of the serial flash operation control block
`timescale 1ns/1ns
`default_nettype none
module serial_flash_op_control_tb
  import sfoc_pkg::*;
();
  localparam int XC = 200;
  localparam int EC = 500;
  localparam int PC = 1000;
  localparam int PEC = 300;
  localparam int BC = 350;
  logic sys_clk_i, rst_i, clk_en_i, wp_n_i, reset_n_i, array_mismatch_i;
  logic spi_sck, spi_cs_n, spi_si, spi_so_o, spi_so_oe_o, rdy_busy_o, rdy_busy_oe_o;
  logic spi_mode3_o, array_start_o, array_buf_o, array_abort_o, cmd_reject_o;
  logic buf_wr_o, buf_wr_sel_o;
  logic [12:0] array_page_o;
  logic [9:0] buf_wr_addr_o;
  logic [7:0] buf_wr_data_o;
  logic [7:0] rx_v;
  sfoc_kind_t array_kind_o;
  wire so_w;
  int err_total = 0;
  int tests_run = 0;
  int n_start = 0;
  int n_rej = 0;
  int n_abort = 0;
  int busy_cnt = 0;
  logic [18:0] wr_q[$];
  logic [7:0] opc_t [10] = '{8'h53, 8'h61, 8'h83, 8'h89, 8'h81, 8'h50, 8'h85, 8'h58,
                             8'h60, 8'h86};
  sfoc_kind_t kind_t [10] = '{K_XFER, K_CMP, K_PGM_ER, K_PGM, K_PERASE, K_BERASE,
                              K_MMPROG, K_REWRITE, K_CMP, K_PGM_ER};
  int cyc_t [10] = '{XC, XC, EC, PC, PEC, BC, EC, EC, XC, EC};
  logic buf_t [10] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};

  assign so_w = spi_so_oe_o ? spi_so_o : 1'bz;

  sfoc_top #(.XFR_CYC(XC), .EP_CYC(EC), .P_CYC(PC), .PE_CYC(PEC), .BE_CYC(BC)) sfoc_top_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .spi_sck_i(spi_sck),
    .spi_cs_n_i(spi_cs_n), .spi_si_i(spi_si), .wp_n_i(wp_n_i), .reset_n_i(reset_n_i),
    .array_mismatch_i(array_mismatch_i), .spi_so_o(spi_so_o), .spi_so_oe_o(spi_so_oe_o),
    .rdy_busy_o(rdy_busy_o), .rdy_busy_oe_o(rdy_busy_oe_o), .spi_mode3_o(spi_mode3_o),
    .array_start_o(array_start_o), .array_kind_o(array_kind_o), .array_page_o(array_page_o),
    .array_buf_o(array_buf_o), .array_abort_o(array_abort_o), .cmd_reject_o(cmd_reject_o),
    .buf_wr_o(buf_wr_o), .buf_wr_sel_o(buf_wr_sel_o), .buf_wr_addr_o(buf_wr_addr_o),
    .buf_wr_data_o(buf_wr_data_o));

  sfoc_host_model sfoc_host_model_inst (
    .so_i(so_w), .sck_o(spi_sck), .cs_n_o(spi_cs_n), .si_o(spi_si));

  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  // Pulse counters, busy length and buffer write log
  always @(posedge sys_clk_i) begin
    if (array_start_o === 1'b1) busy_cnt <= 1;
    else if (rdy_busy_oe_o === 1'b1) busy_cnt <= busy_cnt + 1;
    if (array_start_o === 1'b1) n_start <= n_start + 1;
    if (cmd_reject_o === 1'b1) n_rej <= n_rej + 1;
    if (array_abort_o === 1'b1) n_abort <= n_abort + 1;
    if (buf_wr_o === 1'b1) wr_q.push_back({buf_wr_sel_o, buf_wr_addr_o, buf_wr_data_o});
  end

  function automatic logic [31:0] cmdw(input logic [7:0] opc, input logic [12:0] pg,
                                       input logic [9:0] ba);
    cmdw = {opc, 1'b0, pg, ba};
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
      err_total++;
    end
  endtask

  task automatic give_verdict();
    if (err_total == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic send(input logic m3, input logic [31:0] cmd, input int nb,
                      input logic [7:0] dat, input int es, input int er);
    int s0;
    int r0;
    int k;
    s0 = n_start;
    r0 = n_rej;
    sfoc_host_model_inst.frame(m3, cmd, nb, dat, rx_v);
    for (k = 0; k < 8 && n_start == s0 && n_rej == r0; k++) @(posedge sys_clk_i);
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk("start count", es, n_start - s0);
    chk("reject count", er, n_rej - r0);
  endtask

  task automatic wait_idle();
    int k;
    for (k = 0; k < 3000 && rdy_busy_oe_o !== 1'b0; k++) @(posedge sys_clk_i);
    #1;
    if (k == 3000) begin
      $display("[ERR] busy wait expected 0 seen 1");
      err_total++;
      give_verdict();
    end
  endtask

  task automatic status(input logic m3, input logic exp7);
    send(m3, {OPC_STATUS, 24'h00_0000}, 1, 8'h00, 0, 0);
    chk("ready bit", exp7, rx_v[7]);
  endtask

  initial begin
    int i;
    int a0;
    rst_i = 1'b1;
    clk_en_i = 1'b1;
    wp_n_i = 1'b1;
    reset_n_i = 1'b1;
    array_mismatch_i = 1'b0;
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (5) @(posedge sys_clk_i);
    #1;
    chk("mode3", 1, spi_mode3_o);
    chk("so enable", 0, spi_so_oe_o);
    chk("busy enable", 0, rdy_busy_oe_o);
    status(1'b0, 1'b1);
    chk("mode3", 0, spi_mode3_o);
    chk("density", 32'(DENSITY_ID), rx_v[5:3]);
    status(1'b1, 1'b1);
    chk("mode3", 1, spi_mode3_o);
    for (i = 0; i < 10; i++) begin
      @(posedge sys_clk_i);
      array_mismatch_i <= i[0];
      send(i[0], cmdw(opc_t[i], 13'h012c, 10'h000), 0, 8'h00, 1, 0);
      chk("kind", 32'(kind_t[i]), array_kind_o);
      chk("page", 32'h0000_012c, array_page_o);
      chk("buffer", 32'(buf_t[i]), array_buf_o);
      wait_idle();
      chk("busy length", cyc_t[i], busy_cnt);
      chk("open drain level", 0, rdy_busy_o);
      status(1'b1, 1'b1);
      if (kind_t[i] == K_CMP) chk("compare bit", 32'(i[0]), rx_v[6]);
    end
    @(posedge sys_clk_i);
    wp_n_i <= 1'b0;
    send(1'b1, cmdw(8'h81, 13'h00ff, 10'h000), 0, 8'h00, 0, 1);
    send(1'b1, cmdw(8'h88, 13'h0000, 10'h000), 0, 8'h00, 0, 1);
    send(1'b1, cmdw(8'h81, 13'h0100, 10'h000), 0, 8'h00, 1, 0);
    wait_idle();
    @(posedge sys_clk_i);
    wp_n_i <= 1'b1;
    send(1'b1, cmdw(8'h81, 13'h00ff, 10'h000), 0, 8'h00, 1, 0);
    wait_idle();
    send(1'b1, cmdw(8'h88, 13'h012c, 10'h000), 0, 8'h00, 1, 0);
    wr_q.delete();
    send(1'b1, cmdw(8'h87, 13'h0000, 10'h20f), 2, 8'h5a, 0, 0);
    chk("write count", 2, wr_q.size());
    if (wr_q.size() == 2) begin
      chk("first write", {13'h0000, 1'b1, 10'h20f, 8'h5a}, wr_q[0]);
      chk("wrapped write", {13'h0000, 1'b1, 10'h000, 8'h5b}, wr_q[1]);
    end
    send(1'b0, cmdw(8'h84, 13'h0000, 10'h000), 1, 8'h11, 0, 1);
    send(1'b1, cmdw(8'h81, 13'h0190, 10'h000), 0, 8'h00, 0, 1);
    status(1'b1, 1'b0);
    wait_idle();
    chk("busy length", PC, busy_cnt);
    send(1'b0, cmdw(8'h83, 13'h012c, 10'h000), 0, 8'h00, 1, 0);
    repeat (20) @(posedge sys_clk_i);
    a0 = n_abort;
    reset_n_i <= 1'b0;
    repeat (5) @(posedge sys_clk_i);
    #1;
    chk("busy enable", 0, rdy_busy_oe_o);
    chk("abort count", 1, n_abort - a0);
    chk("mode3", 1, spi_mode3_o);
    send(1'b1, cmdw(8'h81, 13'h012c, 10'h000), 0, 8'h00, 0, 0);
    @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    send(1'b1, cmdw(8'h81, 13'h012c, 10'h000), 0, 8'h00, 1, 0);
    wait_idle();
    give_verdict();
  end
endmodule
`default_nettype wire
